// ### rtl/timer_cc_params.svh
/*
   Offsets, field positions, reset values and counts of the two-channel
   capture/compare/PWM timer. Included by every design file that needs them.
*/
`ifndef TIMER_CC_PARAMS_SVH
`define TIMER_CC_PARAMS_SVH

`define OFF_TIMER_SC   8'h00
`define OFF_COUNT      8'h04
`define OFF_MODULO     8'h08
`define OFF_CH0_SC     8'h10
`define OFF_CH0_HI     8'h14
`define OFF_CH0_LO     8'h18
`define OFF_CH1_SC     8'h1c
`define OFF_CH1_HI     8'h20
`define OFF_CH1_LO     8'h24
`define OFF_PIN_STATUS 8'h28

`define SC_FLAG        7
`define SC_IRQ_EN      6
`define SC_BUF_SEL     5
`define SC_MODE_A      4
`define SC_ELS_HI      3
`define SC_ELS_LO      2
`define SC_TOGGLE_WRAP 1
`define SC_FULL_DUTY   0

`define TS_WRAP_FLAG   7
`define TS_HALT        5
`define TS_CNT_RESET   4
`define TS_PS_HI       2
`define TS_PS_LO       0

`define RST_HALT       1'b1
`define RST_PRESCALE   3'h0
`define RST_MODULO     16'hffff
`define PS_UNUSED      3'h7
`define PRESCALE_BITS  6

`endif

// ### rtl/timer_cc_pkg.sv
/*
   Types shared by the timer design files.
   Assumes nothing of its surroundings.
*/
package timer_cc_pkg;

   typedef enum logic [1:0] {
      MODE_PRESET   = 2'b00,
      MODE_CAPTURE  = 2'b01,
      MODE_COMPARE  = 2'b10,
      MODE_BUFFERED = 2'b11
   } chan_mode_t;

   typedef enum logic [1:0] {
      BUS_IDLE      = 2'b00,
      BUS_WRITE     = 2'b01,
      BUS_READ_WAIT = 2'b10,
      BUS_READ_DATA = 2'b11
   } bus_state_t;

endpackage

// ### rtl/timer_cc_top.sv
/*
   Two-channel capture/compare/PWM timer with an AHB-Lite register slave.
   Assumes a single AHB-Lite master on hclk, whole-word single transfers,
   and channel pins that arrive asynchronously.
*/
// Behaviour
// R01: A selected capture edge on the pin sets the channel event flag.
// R02: In compare mode a counter match with the channel value sets the flag.
// R03: Flag clears by status read with flag set then writing zero; new event wins.
// R04: Writing one to the flag does nothing; reset clears flag and control bits.
// R05: Interrupt request is asserted only while enable and flag are both set; chan_irq is registered and follows them one hclk later.
// R06: Channel 0 buffered select disables channel 1 control and releases its pin.
// R07: With edge bits nonzero and unbuffered, mode A picks capture or compare.
// R08: With edge bits zero, mode A picks the preset level: one low, zero high.
// R09: Edge bits zero leave the pin to the port; enabled modes show preset.
// R10: Capture edge settings 01, 10, 11 select rising, falling, either edge.
// R11: Unbuffered compare settings 00..11 keep, toggle, clear, set the pin.
// R12: Buffered compare settings 01, 10, 11 toggle, clear, set regardless of A.
// R13: Toggle-on-wrap flips a compare pin on overflow; capture ignores it.
// R14: With toggle-on-wrap, overflow action beats a coincident compare action.
// R15: Full-duty with wrap toggle and clear mode holds output high from next period.
// R16: For zero duty software selects clear mode with wrap toggle and full-duty off.
// R17: Channel value holds capture or compare value; reset leaves it undefined.
// R18: Reading the high byte in capture mode blocks captures until low byte read.
// R19: Writing the high byte in compare mode blocks matches until low byte written.
// R20: Software should halt and clear the counter before changing mode bits.
// R21: The capture pin should be stable two bus clocks before capture is enabled.
// R22: Counter reaching modulo sets the wrap flag and restarts from zero next tick.
// R23: While the counter is halted captures are inhibited.
// R24: A debug break stops the counter and inhibits captures.
// R25: Matches, wraps and edges are evaluated on the timer clock; pin is registered.
`timescale 1ns/100ps
`include "timer_cc_params.svh"

module timer_cc_top (
   // Clock and reset
   input  wire logic        hclk,
   input  wire logic        hresetn,
   // AHB-Lite slave
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic [31:0]      hrdata,
   output logic             hresp,
   // System
   input  wire logic        debug_break,
   output logic [1:0]       chan_irq,
   // Channel pins
   input  wire logic [1:0]  channel_pin_in,
   output logic [1:0]       channel_pin_out,
   output logic [1:0]       channel_pin_oe
);

   // Bus state.
   timer_cc_pkg::bus_state_t bus_state;
   timer_cc_pkg::bus_state_t next_bus_state;
   logic [7:0]  addr_q;
   logic [7:0]  next_addr_q;
   logic [31:0] next_hrdata;
   logic        next_hreadyout;
   logic        accept;
   logic        wr_en;
   logic        rd_en;
   logic [31:0] rd_word;

   // Timer control state.
   logic        wrap_flag;
   logic        wrap_armed;
   logic        halt;
   logic [2:0]  prescale;
   logic [15:0] modulo;
   logic        next_wrap_flag;
   logic        next_wrap_armed;
   logic        next_halt;
   logic [2:0]  next_prescale;
   logic [15:0] next_modulo;
   logic        cnt_clear;
   logic        next_cnt_clear;

   // Channel state.
   logic [1:0]  flag;
   logic [1:0]  armed;
   logic [1:0]  irq_en;
   logic        buf_sel;
   logic [1:0]  mode_a;
   logic [1:0]  els_hi;
   logic [1:0]  els_lo;
   logic [1:0]  tow;
   logic [1:0]  fdf;
   logic [1:0]  rlock;
   logic [1:0]  wlock;
   logic        buf_phase;
   logic [1:0]  next_flag;
   logic [1:0]  next_armed;
   logic [1:0]  next_irq_en;
   logic        next_buf_sel;
   logic [1:0]  next_mode_a;
   logic [1:0]  next_els_hi;
   logic [1:0]  next_els_lo;
   logic [1:0]  next_tow;
   logic [1:0]  next_fdf;
   logic [1:0]  next_rlock;
   logic [1:0]  next_wlock;
   logic        next_buf_phase;
   logic [15:0] value [2];
   logic [15:0] next_value [2];

   // Counter and channel wiring.
   logic [15:0] count;
   logic        step;
   logic        overflow;
   logic [1:0]  pin_meta;
   logic [1:0]  pin_sync;
   logic [1:0]  cap_pulse;
   logic [1:0]  cmp_pulse;
   logic [15:0] cap_word [2];
   logic [15:0] cmp_value [2];
   logic [1:0]  is_capture;
   logic [1:0]  is_output;
   logic [1:0]  chan_off;
   logic [7:0]  sc_read [2];
   logic [1:0]  cap_allow;

   always_comb begin
      accept  = hsel && hready && htrans[1];
      wr_en   = (bus_state == timer_cc_pkg::BUS_WRITE);
      rd_en   = (bus_state == timer_cc_pkg::BUS_READ_WAIT);
      overflow = step && (count == modulo); // R22
      // Channel 1 control is dead while channel 0 runs buffered.
      chan_off = {buf_sel, 1'b0}; // R06
      for (int i = 0; i < 2; i++) begin
         is_capture[i] = !chan_off[i] && !(i == 0 && buf_sel) && !mode_a[i] &&
                         (els_hi[i] || els_lo[i]);
         is_output[i]  = !chan_off[i] && (els_hi[i] || els_lo[i]) &&
                         (mode_a[i] || (i == 0 && buf_sel));
         cap_allow[i]  = !rlock[i] && !halt && !debug_break; // R18 R23 R24
         sc_read[i]    = chan_off[i] ? 8'h00 :
                         {flag[i], irq_en[i], (i == 0) ? buf_sel : 1'b0, mode_a[i],
                          els_hi[i], els_lo[i], tow[i], fdf[i]};
      end
      // In buffered mode channel 0 alternates between both value registers.
      cmp_value[0] = (buf_sel && buf_phase) ? value[1] : value[0]; // R12
      cmp_value[1] = value[1];
   end

   // Read multiplexer.
   always_comb begin
      case (addr_q)
         `OFF_TIMER_SC:   rd_word = {24'h000000, wrap_flag, 1'b0, halt, 1'b0, 1'b0, prescale};
         `OFF_COUNT:      rd_word = {16'h0000, count};
         `OFF_MODULO:     rd_word = {16'h0000, modulo};
         `OFF_CH0_SC:     rd_word = {24'h000000, sc_read[0]};
         `OFF_CH0_HI:     rd_word = {24'h000000, value[0][15:8]};
         `OFF_CH0_LO:     rd_word = {24'h000000, value[0][7:0]};
         `OFF_CH1_SC:     rd_word = {24'h000000, sc_read[1]};
         `OFF_CH1_HI:     rd_word = {24'h000000, value[1][15:8]};
         `OFF_CH1_LO:     rd_word = {24'h000000, value[1][7:0]};
         `OFF_PIN_STATUS: rd_word = {26'h0000000, channel_pin_oe, pin_sync, channel_pin_out};
         default:         rd_word = 32'h00000000;
      endcase
   end

   // Bus sequencing: writes take no wait state, reads take one.
   always_comb begin
      next_bus_state = bus_state;
      next_addr_q    = addr_q;
      next_hrdata    = hrdata;
      next_hreadyout = 1'b1;
      case (bus_state)
         timer_cc_pkg::BUS_READ_WAIT: begin
            next_hrdata    = rd_word;
            next_bus_state = timer_cc_pkg::BUS_READ_DATA;
         end
         default: begin
            if (accept) begin
               next_addr_q = haddr[7:0];
               if (hwrite) begin
                  next_bus_state = timer_cc_pkg::BUS_WRITE;
               end else begin
                  next_bus_state = timer_cc_pkg::BUS_READ_WAIT;
                  next_hreadyout = 1'b0;
               end
            end else begin
               next_bus_state = timer_cc_pkg::BUS_IDLE;
            end
         end
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         bus_state <= timer_cc_pkg::BUS_IDLE;
         addr_q    <= 8'h00;
         hrdata    <= 32'h00000000;
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end else begin
         bus_state <= next_bus_state;
         addr_q    <= next_addr_q;
         hrdata    <= next_hrdata;
         hreadyout <= next_hreadyout;
         hresp     <= 1'b0;
      end
   end

   // Timer control register.
   always_comb begin
      next_wrap_flag  = wrap_flag;
      next_wrap_armed = wrap_armed;
      next_halt       = halt;
      next_prescale   = prescale;
      next_modulo     = modulo;
      next_cnt_clear  = 1'b0;
      if (rd_en && addr_q == `OFF_TIMER_SC) begin
         next_wrap_armed = wrap_flag;
      end
      if (wr_en && addr_q == `OFF_TIMER_SC) begin
         next_halt      = hwdata[`TS_HALT];
         next_prescale  = hwdata[`TS_PS_HI:`TS_PS_LO];
         next_cnt_clear = hwdata[`TS_CNT_RESET];
         if (wrap_armed && !hwdata[`TS_WRAP_FLAG]) begin
            next_wrap_flag = 1'b0;
         end
         next_wrap_armed = 1'b0;
      end
      if (wr_en && addr_q == `OFF_MODULO) begin
         next_modulo = hwdata[15:0];
      end
      // A wrap in the clearing cycle keeps the flag set.
      if (overflow) begin
         next_wrap_flag  = 1'b1; // R22
         next_wrap_armed = 1'b0;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wrap_flag  <= 1'b0;
         wrap_armed <= 1'b0;
         halt       <= `RST_HALT;
         prescale   <= `RST_PRESCALE;
         modulo     <= `RST_MODULO;
         cnt_clear  <= 1'b0;
      end else begin
         wrap_flag  <= next_wrap_flag;
         wrap_armed <= next_wrap_armed;
         halt       <= next_halt;
         prescale   <= next_prescale;
         modulo     <= next_modulo;
         cnt_clear  <= next_cnt_clear;
      end
   end

   // Channel control and status.
   always_comb begin
      next_flag      = flag;
      next_armed     = armed;
      next_irq_en    = irq_en;
      next_buf_sel   = buf_sel;
      next_mode_a    = mode_a;
      next_els_hi    = els_hi;
      next_els_lo    = els_lo;
      next_tow       = tow;
      next_fdf       = fdf;
      next_rlock     = rlock;
      next_wlock     = wlock;
      next_buf_phase = buf_sel ? (buf_phase ^ overflow) : 1'b0;
      for (int i = 0; i < 2; i++) begin
         if (rd_en && !chan_off[i] && addr_q == ((i == 0) ? `OFF_CH0_SC : `OFF_CH1_SC)) begin
            next_armed[i] = flag[i]; // R03
         end
         if (rd_en && is_capture[i] && addr_q == ((i == 0) ? `OFF_CH0_HI : `OFF_CH1_HI)) begin
            next_rlock[i] = 1'b1; // R18
         end
         if (rd_en && addr_q == ((i == 0) ? `OFF_CH0_LO : `OFF_CH1_LO)) begin
            next_rlock[i] = 1'b0;
         end
         if (wr_en && !is_capture[i] && addr_q == ((i == 0) ? `OFF_CH0_HI : `OFF_CH1_HI)) begin
            next_wlock[i] = 1'b1; // R19
         end
         if (wr_en && addr_q == ((i == 0) ? `OFF_CH0_LO : `OFF_CH1_LO)) begin
            next_wlock[i] = 1'b0;
         end
         if (wr_en && !chan_off[i] && addr_q == ((i == 0) ? `OFF_CH0_SC : `OFF_CH1_SC)) begin
            next_irq_en[i] = hwdata[`SC_IRQ_EN];
            next_mode_a[i] = hwdata[`SC_MODE_A];
            next_els_hi[i] = hwdata[`SC_ELS_HI];
            next_els_lo[i] = hwdata[`SC_ELS_LO];
            next_tow[i]    = hwdata[`SC_TOGGLE_WRAP];
            next_fdf[i]    = hwdata[`SC_FULL_DUTY];
            if (i == 0) begin
               next_buf_sel = hwdata[`SC_BUF_SEL]; // R06
            end
            // Writing one to the flag is ignored.
            if (armed[i] && !hwdata[`SC_FLAG]) begin // R04
               next_flag[i] = 1'b0; // R03
            end
            next_armed[i] = 1'b0;
         end
         // An event in the clearing cycle wins over the clear.
         if (cap_pulse[i] || cmp_pulse[i]) begin
            next_flag[i]  = 1'b1; // R01 R02 R03
            next_armed[i] = 1'b0;
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         flag      <= 2'b00; // R04
         armed     <= 2'b00;
         irq_en    <= 2'b00;
         buf_sel   <= 1'b0;
         mode_a    <= 2'b00;
         els_hi    <= 2'b00;
         els_lo    <= 2'b00;
         tow       <= 2'b00;
         fdf       <= 2'b00;
         rlock     <= 2'b00;
         wlock     <= 2'b00;
         buf_phase <= 1'b0;
         chan_irq  <= 2'b00;
      end else begin
         flag      <= next_flag;
         armed     <= next_armed;
         irq_en    <= next_irq_en;
         buf_sel   <= next_buf_sel;
         mode_a    <= next_mode_a;
         els_hi    <= next_els_hi;
         els_lo    <= next_els_lo;
         tow       <= next_tow;
         fdf       <= next_fdf;
         rlock     <= next_rlock;
         wlock     <= next_wlock;
         buf_phase <= next_buf_phase;
         chan_irq  <= irq_en & flag; // R05
      end
   end

   // Channel values carry no reset: their content after reset is undefined.
   always_comb begin
      for (int i = 0; i < 2; i++) begin
         next_value[i] = value[i];
         if (wr_en && addr_q == ((i == 0) ? `OFF_CH0_HI : `OFF_CH1_HI)) begin
            next_value[i][15:8] = hwdata[7:0];
         end
         if (wr_en && addr_q == ((i == 0) ? `OFF_CH0_LO : `OFF_CH1_LO)) begin
            next_value[i][7:0] = hwdata[7:0];
         end
         if (cap_pulse[i]) begin
            next_value[i] = cap_word[i]; // R17
         end
      end
   end

   always_ff @(posedge hclk) begin
      value <= next_value;
   end

   // Pins are asynchronous, so each passes two flip-flops.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pin_meta <= 2'b00;
         pin_sync <= 2'b00;
      end else begin
         pin_meta <= channel_pin_in;
         pin_sync <= pin_meta;
      end
   end

   timer_counter u_counter (
      .hclk          (hclk),
      .hresetn       (hresetn),
      .prescale_sel  (prescale),
      .counter_halt  (halt),
      .debug_break   (debug_break),
      .counter_clear (cnt_clear),
      .modulo        (modulo),
      .count         (count),
      .step          (step)
   );

   for (genvar g = 0; g < 2; g++) begin : g_chan
      timer_channel u_chan (
         .hclk            (hclk),
         .hresetn         (hresetn),
         .disabled        (chan_off[g]),
         .buffered        ((g == 0) ? buf_sel : 1'b0),
         .mode_a          (mode_a[g]),
         .els             ({els_hi[g], els_lo[g]}),
         .toggle_on_wrap  (tow[g]),
         .full_duty_force (fdf[g]),
         .step            (step),
         .overflow        (overflow),
         .count           (count),
         .cmp_value       (cmp_value[g]),
         .capture_allow   (cap_allow[g]),
         .compare_allow   (!wlock[g] && is_output[g]),
         .pin_level       (pin_sync[g]),
         .pin_out         (channel_pin_out[g]),
         .pin_oe          (channel_pin_oe[g]),
         .capture_pulse   (cap_pulse[g]),
         .compare_pulse   (cmp_pulse[g]),
         .capture_word    (cap_word[g])
      );
   end

endmodule

// ### rtl/timer_channel.sv
/*
   One capture/compare/PWM channel: edge detection, compare match and the
   registered pin driver. Assumes the pin level is already synchronised.
*/
`timescale 1ns/100ps

module timer_channel (
   // Clock and reset
   input  wire logic        hclk,
   input  wire logic        hresetn,
   // Configuration
   input  wire logic        disabled,
   input  wire logic        buffered,
   input  wire logic        mode_a,
   input  wire logic [1:0]  els,
   input  wire logic        toggle_on_wrap,
   input  wire logic        full_duty_force,
   // Counter
   input  wire logic        step,
   input  wire logic        overflow,
   input  wire logic [15:0] count,
   input  wire logic [15:0] cmp_value,
   input  wire logic        capture_allow,
   input  wire logic        compare_allow,
   // Pin
   input  wire logic        pin_level,
   output logic             pin_out,
   output logic             pin_oe,
   // Events
   output logic             capture_pulse,
   output logic             compare_pulse,
   output logic [15:0]      capture_word
);

   timer_cc_pkg::chan_mode_t mode;
   logic        prev_level;
   logic        full_latched;
   logic        next_out;
   logic        next_full;
   logic        cap_hit;
   logic        match;
   logic        wrap_act;
   logic        outputs;

   always_comb begin
      if (disabled || els == 2'b00) begin
         mode = timer_cc_pkg::MODE_PRESET; // R09
      end else if (buffered) begin
         mode = timer_cc_pkg::MODE_BUFFERED; // R12
      end else if (mode_a) begin
         mode = timer_cc_pkg::MODE_COMPARE; // R07
      end else begin
         mode = timer_cc_pkg::MODE_CAPTURE; // R07
      end
      outputs  = (mode == timer_cc_pkg::MODE_COMPARE) || (mode == timer_cc_pkg::MODE_BUFFERED);
      cap_hit  = (mode == timer_cc_pkg::MODE_CAPTURE) && capture_allow &&
                 ((els[0] && pin_level && !prev_level) ||
                  (els[1] && !pin_level && prev_level)); // R10
      match    = outputs && step && (count == cmp_value) && compare_allow; // R02
      wrap_act = outputs && toggle_on_wrap && overflow; // R13
      next_full = overflow ? full_duty_force : full_latched; // R15
      next_out  = pin_out;
      case (mode)
         timer_cc_pkg::MODE_PRESET: begin
            next_out = !mode_a; // R08
         end
         timer_cc_pkg::MODE_CAPTURE: begin
            next_out = pin_out;
         end
         default: begin
            if (wrap_act) begin
               // Overflow wins over a coincident match.
               if (els == 2'b10 && full_duty_force) begin // R14
                  next_out = 1'b1; // R15
               end else begin
                  next_out = !pin_out;
               end
            end else if (match && !(els == 2'b10 && full_latched && toggle_on_wrap)) begin
               case (els)
                  2'b01:   next_out = !pin_out; // R11
                  2'b10:   next_out = 1'b0;
                  2'b11:   next_out = 1'b1;
                  default: next_out = pin_out;
               endcase
            end
         end
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         prev_level    <= 1'b0;
         full_latched  <= 1'b0;
         pin_out       <= 1'b1;
         pin_oe        <= 1'b0;
         capture_pulse <= 1'b0;
         compare_pulse <= 1'b0;
         capture_word  <= 16'h0000;
      end else begin
         prev_level    <= pin_level;
         full_latched  <= next_full;
         pin_out       <= next_out; // R25
         pin_oe        <= outputs; // R09
         capture_pulse <= cap_hit; // R01
         compare_pulse <= match;
         capture_word  <= cap_hit ? count : capture_word;
      end
   end

endmodule

// ### rtl/timer_counter.sv
/*
   Prescaler and 16-bit modulo up-counter.
   Assumes all controls come from logic on hclk.
*/
`timescale 1ns/100ps
`include "timer_cc_params.svh"

module timer_counter (
   // Clock and reset
   input  wire logic        hclk,
   input  wire logic        hresetn,
   // Control
   input  wire logic [2:0]  prescale_sel,
   input  wire logic        counter_halt,
   input  wire logic        debug_break,
   input  wire logic        counter_clear,
   input  wire logic [15:0] modulo,
   // State
   output logic      [15:0] count,
   output logic             step
);

   logic [`PRESCALE_BITS-1:0] pdiv;
   logic [`PRESCALE_BITS-1:0] next_pdiv;
   logic [`PRESCALE_BITS-1:0] mask;
   logic [`PRESCALE_BITS:0]   one_hot;
   logic [15:0]               next_count;
   logic                      next_step;
   logic                      run;
   logic                      tick;

   always_comb begin
      run        = !counter_halt && !debug_break; // R24
      one_hot    = (`PRESCALE_BITS+1)'(1) << prescale_sel;
      mask       = one_hot[`PRESCALE_BITS-1:0] - `PRESCALE_BITS'(1);
      tick       = run && (prescale_sel != `PS_UNUSED) && ((pdiv & mask) == mask);
      next_pdiv  = pdiv;
      next_count = count;
      if (counter_clear) begin
         next_pdiv  = '0;
         next_count = '0;
      end else begin
         if (run) begin
            next_pdiv = pdiv + `PRESCALE_BITS'(1);
         end
         if (tick) begin
            next_count = (count == modulo) ? 16'h0000 : count + 16'h0001; // R22
         end
      end
      next_step = tick && !counter_clear;
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pdiv  <= '0;
         count <= 16'h0000;
         step  <= 1'b0;
      end else begin
         pdiv  <= next_pdiv;
         count <= next_count;
         step  <= next_step;
      end
   end

endmodule

// ### tb/timer_cc_properties.sv
/* Checker of the timer top ports.
   Assumes one bus master with hready tied to hreadyout. */
`timescale 1ns/100ps
module timer_cc_properties (
   // Clock and reset
   input wire logic        hclk,
   input wire logic        hresetn,
   // Bus
   input wire logic        hsel,
   input wire logic [1:0]  htrans,
   input wire logic        hwrite,
   input wire logic        hready,
   input wire logic        hreadyout,
   input wire logic [31:0] hrdata,
   input wire logic        hresp,
   // Channels
   input wire logic [1:0]  chan_irq,
   input wire logic [1:0]  channel_pin_oe
);
   logic       wdp;
   logic       ever;
   logic [1:0] quiet;
   // Counts cycles since a write, so config effects can be tied to it.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wdp <= 1'b0;
         ever <= 1'b0;
         quiet <= 2'h3;
      end else begin
         wdp <= hsel && hready && htrans[1] && hwrite;
         ever <= ever | wdp;
         quiet <= wdp ? 2'h0 : (quiet == 2'h3 ? quiet : quiet + 2'h1);
      end
   end
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   sequence rd_req;
      hsel && hready && htrans[1] && !hwrite;
   endsequence
   a_read_wait: assert property (rd_req |=> !hreadyout ##1 hreadyout)
      else $error("read wait wrong");
   a_write_nowait: assert property (hsel && hready && htrans[1] && hwrite |=> hreadyout)
      else $error("write wait wrong");
   a_ready_one: assert property (!hreadyout |=> hreadyout)
      else $error("long wait");
   a_resp_okay: assert property (hresp == 1'b0)
      else $error("error response");
   a_irq_reset: assert property (!ever |-> chan_irq == 2'h0)
      else $error("irq after reset");
   a_irq_fall: assert property (|($past(chan_irq) & ~chan_irq) |-> quiet != 2'h3)
      else $error("irq fell alone");
   a_oe_write: assert property ($changed(channel_pin_oe) |-> quiet != 2'h3)
      else $error("oe moved alone");
   a_rdata_hold: assert property ($changed(hrdata) |-> !hreadyout || $past(!hreadyout))
      else $error("read data moved");
endmodule
bind timer_cc_top timer_cc_properties chk_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
   .htrans(htrans), .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout),
   .hrdata(hrdata), .hresp(hresp), .chan_irq(chan_irq), .channel_pin_oe(channel_pin_oe));

// ### tb/timer_channel_capture_compare_pwm_test.sv
/* Bench: capture, compare and buffered tests over the register bus.
   Assumes the timer design and the pin model. */
`timescale 1ns/100ps
module timer_channel_capture_compare_pwm_test;
   logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, debug_break = 0, hreadyout, hresp;
   logic [1:0] htrans = 2'h0, ext = 2'h0, pin_in, pout, poe, chan_irq;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, r;
   int miscompares = 0, checks = 0;
   always #25 hclk = ~hclk;
   timer_cc_top dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .debug_break(debug_break),
      .chan_irq(chan_irq), .channel_pin_in(pin_in), .channel_pin_out(pout), .channel_pin_oe(poe));
   timer_pin_partner pin_u (.drive_level(ext), .pin_out(pout), .pin_oe(poe), .pin_in(pin_in));
   task automatic chk(input string n, input logic [7:0] e, g);
      checks++;
      if (e !== g) begin
         $display("mismatch %s expected %h seen %h", n, e, g);
         miscompares++;
      end
   endtask
   task automatic bus(input logic w, input logic [7:0] a, d);
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= {24'h0, a};
      hwrite <= w;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= {24'h0, d};
      do @(posedge hclk); while (hreadyout !== 1'b1);
      r = hrdata;
   endtask
   task automatic rd(input logic [7:0] a, e);
      bus(1'b0, a, 8'h0);
      chk("register", e, r[7:0]);
   endtask
   task automatic give_verdict;
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   initial begin
      repeat (5) @(posedge hclk);
      hresetn <= 1'b1;
      rd(8'h10, 8'h00);
      rd(8'h1c, 8'h00);
      bus(1'b1, 8'h00, 8'h00);
      bus(1'b1, 8'h10, 8'h44);
      repeat (4) @(posedge hclk);
      ext[0] <= 1'b1;
      repeat (8) @(posedge hclk);
      rd(8'h10, 8'hc4);
      chk("irq", 8'h1, {7'h0, chan_irq[0]});
      chk("oe", 8'h0, {7'h0, poe[0]});
      bus(1'b1, 8'h10, 8'h44);
      bus(1'b1, 8'h10, 8'hc4);
      rd(8'h10, 8'h44);
      ext[0] <= 1'b0;
      repeat (8) @(posedge hclk);
      rd(8'h10, 8'h44);
      debug_break <= 1'b1;
      ext[0] <= 1'b1;
      repeat (8) @(posedge hclk);
      rd(8'h10, 8'h44);
      debug_break <= 1'b0;
      chk("irq", 8'h0, {7'h0, chan_irq[0]});
      $display("capture test done");
      bus(1'b1, 8'h08, 8'h20);
      bus(1'b1, 8'h20, 8'h00);
      bus(1'b1, 8'h24, 8'h10);
      for (int i = 2; i < 4; i++) begin
         bus(1'b1, 8'h00, 8'h30);
         bus(1'b1, 8'h1c, 8'h10 | 8'(i << 2));
         bus(1'b1, 8'h00, 8'h00);
         chk("oe", 8'h1, {7'h0, poe[1]});
         repeat (40) @(posedge hclk);
         rd(8'h1c, 8'h90 | 8'(i << 2));
         chk("pin", 8'(i & 1), {7'h0, pout[1]});
      end
      $display("compare test done");
      bus(1'b1, 8'h10, 8'h20);
      rd(8'h1c, 8'h00);
      chk("oe", 8'h0, {7'h0, poe[1]});
      $display("buffered test done");
      give_verdict;
   end
   initial begin
      repeat (4000) @(posedge hclk);
      miscompares++;
      give_verdict;
   end
endmodule

// ### tb/timer_pin_partner.sv
/* Pin model: external signal sources on the two channel pins.
   Assumes the bench sets the level that an outside source drives. */
`timescale 1ns/100ps
module timer_pin_partner (
   // Levels
   input  wire logic [1:0] drive_level,
   input  wire logic [1:0] pin_out,
   input  wire logic [1:0] pin_oe,
   output logic      [1:0] pin_in
);
   // A driven pin shows the channel level, a released one the outside level.
   assign pin_in = (pin_oe & pin_out) | (~pin_oe & drive_level);
endmodule
